// file: logic/mxb_consts.svh
// Constants for the multiplexed address/data bus pin sequencer.
// Overview of operation
// - The upper address/status lines carry address bits in the address phase and status in the second, third and fourth bus states.
// - On the sixteen-bit bus the status driven on the upper lines during the data states is always zero.
// - On the eight-bit bus the middle address lines hold a valid address for the whole bus cycle.
// - In the address phase of all but acknowledge cycles address bits 13 to 15 appear on the top three shared lines, ready for the latch strobe.
// - In interrupt acknowledge cycles the top three shared lines carry the cascade select code.
// - In the address phase address bits 0 to 12 appear on the low shared lines, on both the eight-bit and the sixteen-bit bus.
// - After the address phase the shared lines carry the data, the low eight only on the eight-bit bus; the processor drives writes, the far device reads.
// - A three-bit bus cycle status code on its own pins names the kind of cycle being started.
// - The status codes are 0 acknowledge, 1 I/O read, 2 I/O write, 3 halt, 4 fetch, 5 memory read, 6 memory write, 7 passive.
// - The address latch strobe pulses in the address phase so outside transparent latches capture the address.
`ifndef MXB_CONSTS_SVH
`define MXB_CONSTS_SVH
`define MXB_ST_INTA 3'h0
`define MXB_ST_IORD 3'h1
`define MXB_ST_IOWR 3'h2
`define MXB_ST_HALT 3'h3
`define MXB_ST_FETCH 3'h4
`define MXB_ST_MEMRD 3'h5
`define MXB_ST_MEMWR 3'h6
`define MXB_ST_PASSIVE 3'h7
`define MXB_PIN_W 19
`define MXB_UPPER_LSB 16
`define MXB_TOP_LSB 13
`define MXB_MID_LSB 8
`define MXB_RST_PIN_OUT 19'h00000
`define MXB_RST_PIN_OE_N 19'h7ffff
`define MXB_RST_STATUS 3'h7
`define MXB_RST_DATA 16'h0000
`endif

// file: logic/mxb_pkg.sv
// Types shared by the multiplexed bus pin sequencer.
package mxb_pkg;
	typedef enum logic [2:0] {MXB_IDLE, MXB_T1, MXB_T2, MXB_T3, MXB_T4} mxb_state_t;
	typedef logic [2:0] mxb_code_t;
endpackage

// file: logic/mxb_lane.sv
// Registered pin lanes: one output and one active-low enable flip-flop per pin.
`include "mxb_consts.svh"
module mxb_lane
	import mxb_pkg::*;
#(
	parameter int W = `MXB_PIN_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] out_next,
	input wire logic [W-1:0] oe_n_next,
	output logic [W-1:0] out_q,
	output logic [W-1:0] oe_n_q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					out_q[i] <= 1'b0;
					oe_n_q[i] <= 1'b1;
				end else begin
					out_q[i] <= out_next[i];
					oe_n_q[i] <= oe_n_next[i];
				end
			end
		end
	endgenerate
endmodule

// file: logic/mxb_bus.sv
// Bus cycle sequencer driving the multiplexed address, data, status and strobe pins.
`include "mxb_consts.svh"
module mxb_bus
	import mxb_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic BUS8_STRAP,
	input wire logic REQ_VALID,
	input wire logic [2:0] REQ_KIND,
	input wire logic [18:0] REQ_ADDR,
	input wire logic [15:0] REQ_WDATA,
	input wire logic [2:0] REQ_CASCADE,
	input wire logic [2:0] REQ_UPPER_STATUS,
	output logic REQ_READY,
	output logic [15:0] RD_DATA,
	output logic RD_VALID,
	output logic BUS8_MODE,
	output logic [2:0] UPPER_OUT,
	output logic [2:0] UPPER_OE_N,
	input wire logic [15:0] AD_IN,
	output logic [15:0] AD_OUT,
	output logic [15:0] AD_OE_N,
	output logic [2:0] BUS_CYCLE_STATUS_CODE,
	output logic ALE
);
	mxb_state_t state_reg, state_next;
	mxb_code_t kind_reg;
	logic [18:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [2:0] cas_reg;
	logic [2:0] ust_reg;
	logic bus8_reg;
	logic strap_done_reg;
	logic ready_reg;
	logic [15:0] rd_data_reg;
	logic rd_valid_reg;
	logic [2:0] status_reg;
	logic ale_reg;
	logic [18:0] pin_out_q, pin_oe_n_q;

	// Requests are taken only where a new cycle may start, so cycles follow back to back.
	wire slot_free = (state_reg == MXB_IDLE) || (state_reg == MXB_T4);
	// Taking only while REQ_READY shows high keeps the strap edge from starting an unannounced cycle.
	wire accept = REQ_VALID && slot_free && ready_reg && (REQ_KIND != `MXB_ST_PASSIVE);

	wire mxb_code_t kind_n = accept ? REQ_KIND : kind_reg;
	wire [18:0] addr_n = accept ? REQ_ADDR : addr_reg;
	wire [15:0] wdata_n = accept ? REQ_WDATA : wdata_reg;
	wire [2:0] cas_n = accept ? REQ_CASCADE : cas_reg;
	wire [2:0] ust_n = accept ? REQ_UPPER_STATUS : ust_reg;

	// Four states per cycle: address first, then status and data.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MXB_IDLE: state_next = accept ? MXB_T1 : MXB_IDLE;
			MXB_T1: state_next = MXB_T2;
			MXB_T2: state_next = MXB_T3;
			MXB_T3: state_next = MXB_T4;
			MXB_T4: state_next = accept ? MXB_T1 : MXB_IDLE;
			default: state_next = MXB_IDLE;
		endcase
	end

	wire s_addr = (state_next == MXB_T1);
	wire s_data = (state_next == MXB_T2) || (state_next == MXB_T3) || (state_next == MXB_T4);
	wire s_busy = s_addr || s_data;
	wire is_inta = (kind_n == `MXB_ST_INTA);
	wire is_write = (kind_n == `MXB_ST_IOWR) || (kind_n == `MXB_ST_MEMWR);
	wire drive_wdata = s_data && is_write;

	// Upper lines: address first, then status, forced to zero on the wide bus.
	wire [2:0] upper_stat = bus8_reg ? ust_n : 3'h0;
	wire [2:0] upper_n = s_addr ? addr_n[18:16] : (s_data ? upper_stat : 3'h0);
	// Released while idle and in reset; reset leaves them free as test inputs.
	wire [2:0] upper_oe_n = s_busy ? 3'h0 : 3'h7;

	// Top three shared lines: address, cascade code in acknowledge cycles, or data.
	wire [2:0] top_n = (s_busy && is_inta) ? cas_n :
		(s_addr || (s_data && bus8_reg)) ? addr_n[15:13] :
		wdata_n[15:13];
	wire top_drive = (s_busy && is_inta) || s_addr || (s_data && bus8_reg) || drive_wdata;
	wire [2:0] top_oe_n = top_drive ? 3'h0 : 3'h7;

	// Middle lines keep the address through the cycle on the narrow bus.
	wire [4:0] mid_n = (s_addr || (s_data && bus8_reg)) ? addr_n[12:8] : wdata_n[12:8];
	wire mid_drive = s_addr || (s_data && bus8_reg) || (drive_wdata && !bus8_reg);
	wire [4:0] mid_oe_n = mid_drive ? 5'h00 : 5'h1f;

	// Low byte: address in the first state, write data after it; released on reads.
	wire [7:0] low_n = s_addr ? addr_n[7:0] : wdata_n[7:0];
	wire [7:0] low_oe_n = (s_addr || drive_wdata) ? 8'h00 : 8'hff;

	wire [18:0] pin_out_n = {upper_n, top_n, mid_n, low_n};
	wire [18:0] pin_oe_n_n = {upper_oe_n, top_oe_n, mid_oe_n, low_oe_n};

	// Status is valid from the address state into the second state, then goes passive.
	wire [2:0] status_n = (s_addr || (state_next == MXB_T2)) ? kind_n : `MXB_ST_PASSIVE;
	wire ale_n = s_addr;

	// Read data is taken at the end of the third state, one byte wide on the narrow bus.
	wire rd_take = (state_reg == MXB_T3) && (kind_reg != `MXB_ST_HALT) &&
		(kind_reg != `MXB_ST_IOWR) && (kind_reg != `MXB_ST_MEMWR);
	wire [15:0] rd_word = bus8_reg ? {8'h00, AD_IN[7:0]} : AD_IN;
	wire ready_n = strap_done_reg && ((state_next == MXB_IDLE) || (state_next == MXB_T4));

	mxb_lane #(.W(`MXB_PIN_W)) u_lane (
		.clk(CORE_CLK),
		.rst(RST),
		.out_next(pin_out_n),
		.oe_n_next(pin_oe_n_n),
		.out_q(pin_out_q),
		.oe_n_q(pin_oe_n_q)
	);

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_reg <= MXB_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			kind_reg <= `MXB_ST_PASSIVE;
		end else begin
			kind_reg <= kind_n;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			addr_reg <= 19'h00000;
		end else begin
			addr_reg <= addr_n;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			wdata_reg <= `MXB_RST_DATA;
		end else begin
			wdata_reg <= wdata_n;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cas_reg <= 3'h0;
		end else begin
			cas_reg <= cas_n;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ust_reg <= 3'h0;
		end else begin
			ust_reg <= ust_n;
		end
	end

	// The width strap is caught on the first edge after reset is released, never by the reset itself.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			bus8_reg <= 1'b0;
			strap_done_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			bus8_reg <= BUS8_STRAP;
			strap_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			status_reg <= `MXB_RST_STATUS;
		end else begin
			status_reg <= status_n;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ale_reg <= 1'b0;
		end else begin
			ale_reg <= ale_n;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= ready_n;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= rd_take;
		end
	end

	// Read data hold between reads, so a late look still finds the last value.
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rd_data_reg <= `MXB_RST_DATA;
		end else if (rd_take) begin
			rd_data_reg <= rd_word;
		end
	end

	assign REQ_READY = ready_reg;
	assign RD_DATA = rd_data_reg;
	assign RD_VALID = rd_valid_reg;
	assign BUS8_MODE = bus8_reg;
	assign UPPER_OUT = pin_out_q[18:16];
	assign UPPER_OE_N = pin_oe_n_q[18:16];
	assign AD_OUT = pin_out_q[15:0];
	assign AD_OE_N = pin_oe_n_q[15:0];
	assign BUS_CYCLE_STATUS_CODE = status_reg;
	assign ALE = ale_reg;
endmodule

// file: testbench/mxb_bus_props.sv
// Checker for the multiplexed bus pin sequencer ports.
module mxb_bus_props (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic REQ_VALID,
	input wire logic REQ_READY,
	input wire logic [2:0] REQ_KIND,
	input wire logic [18:0] REQ_ADDR,
	input wire logic [2:0] REQ_CASCADE,
	input wire logic BUS8_MODE,
	input wire logic ALE,
	input wire logic [2:0] BUS_CYCLE_STATUS_CODE,
	input wire logic [2:0] UPPER_OUT,
	input wire logic [15:0] AD_OUT,
	input wire logic RD_VALID
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	wire take = REQ_VALID && REQ_READY && REQ_KIND != 3'h7;
	wire [2:0] st = BUS_CYCLE_STATUS_CODE;
	property p_ale; take |=> ALE; endproperty
	a_ale: assert property (p_ale) else $error("no strobe");
	property p_ph; ALE |=> !ALE [*3]; endproperty
	a_ph: assert property (p_ph) else $error("short cycle");
	property p_st; take |=> st == $past(REQ_KIND) ##1 $stable(st) ##1 st == 3'h7; endproperty
	a_st: assert property (p_st) else $error("bad status");
	property p_kind; ALE |-> st != 3'h7; endproperty
	a_kind: assert property (p_kind) else $error("passive start");
	property p_up; take |=> UPPER_OUT == $past(REQ_ADDR[18:16]); endproperty
	a_up: assert property (p_up) else $error("bad upper");
	property p_z; ALE && !BUS8_MODE |=> UPPER_OUT == 3'h0 [*3]; endproperty
	a_z: assert property (p_z) else $error("upper not zero");
	property p_top; take && REQ_KIND != 3'h0 |=> AD_OUT[15:13] == $past(REQ_ADDR[15:13]); endproperty
	a_top: assert property (p_top) else $error("bad top");
	property p_cas; take && REQ_KIND == 3'h0 |=> AD_OUT[15:13] == $past(REQ_CASCADE)
		##1 $stable(AD_OUT[15:13]) [*3]; endproperty
	a_cas: assert property (p_cas) else $error("bad cascade");
	property p_lo; take |=> AD_OUT[12:0] == $past(REQ_ADDR[12:0]); endproperty
	a_lo: assert property (p_lo) else $error("bad low");
	property p_mid; ALE && BUS8_MODE |=> $stable(AD_OUT[15:8]) [*3]; endproperty
	a_mid: assert property (p_mid) else $error("mid moved");
	property p_rd; take && REQ_KIND inside {3'h0, 3'h1, 3'h4, 3'h5} |-> ##4 RD_VALID; endproperty
	a_rd: assert property (p_rd) else $error("no read");
	c_rd: cover property (RD_VALID);
	c_b8: cover property (ALE && BUS8_MODE);
	c_cas: cover property (take && REQ_KIND == 3'h0);
endmodule
bind mxb_bus mxb_bus_props chk (.CORE_CLK, .RST, .REQ_VALID, .REQ_READY, .REQ_KIND, .REQ_ADDR,
	.REQ_CASCADE, .BUS8_MODE, .ALE, .BUS_CYCLE_STATUS_CODE, .UPPER_OUT, .AD_OUT, .RD_VALID);

// file: testbench/mxb_mem.sv
// Far-side memory model: latches the address and answers reads.
module mxb_mem (
	input wire logic clk,
	input wire logic ale,
	input wire logic [15:0] ad_out,
	input wire logic [15:0] ad_oe_n,
	output logic [15:0] ad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] lat = 0;
	logic [1:0] ph = 0;
	logic tog = 0;
	// Outside the two cycles after the strobe a released line toggles, so a stale value can never pass for data.
	wire [15:0] far = (ph == 2'h1 || ph == 2'h2) ? lat ^ 16'ha5a5 : {16{tog}};
	assign ad_in = (~ad_oe_n & ad_out) | (ad_oe_n & far);
	always @(posedge clk) begin
		tog <= ~tog;
		ph <= ale ? 2'h1 : (ph == 2'h0 ? 2'h0 : ph + 2'h1);
		if (ale) lat <= ad_out;
	end
	// The upper lines are never pulled, so they stay free during reset.
endmodule

// file: testbench/test_mxb_bus.sv
// Self-checking bench for the multiplexed bus pin sequencer.
module test_mxb_bus;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, b8 = 0, v = 0, rdy, rv, b8m, ale;
	logic [2:0] k = 0, cs = 0, us = 3'h5, uo, uoe, st;
	logic [18:0] a = 0;
	logic [15:0] wd = 0, ad_in, ad_out, ad_oe_n, rd, m;
	int num_errors = 0, n_compared = 0, cyc = 0;
	mxb_bus dut (.CORE_CLK(clk), .RST(rst), .BUS8_STRAP(b8), .REQ_VALID(v), .REQ_KIND(k),
		.REQ_ADDR(a), .REQ_WDATA(wd), .REQ_CASCADE(cs), .REQ_UPPER_STATUS(us), .REQ_READY(rdy),
		.RD_DATA(rd), .RD_VALID(rv), .BUS8_MODE(b8m), .UPPER_OUT(uo), .UPPER_OE_N(uoe),
		.AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE_N(ad_oe_n), .BUS_CYCLE_STATUS_CODE(st), .ALE(ale));
	mxb_mem mem (.clk(clk), .ale(ale), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_in(ad_in));
	initial forever #10 clk = ~clk;
	always @(posedge clk) if (++cyc == 2000) begin
		num_errors++;
		conclude();
	end
	task automatic chk(logic [18:0] g, logic [18:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task conclude();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic rs(logic s);
		rst <= 1;
		b8 <= s;
		repeat (12) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		#1;
		chk(b8m, s);
	endtask
	task automatic go(logic [2:0] kd, logic [18:0] ad, logic [15:0] d);
		int n = 0;
		logic [15:0] x;
		@(posedge clk);
		v <= 1;
		k <= kd;
		a <= ad;
		wd <= d;
		cs <= ad[15:13];
		m = b8 ? 16'h00ff : 16'hffff;
		do @(posedge clk); while (rdy !== 1'b1 && ++n < 50);
		v <= 0;
		#1;
		chk({ale, st}, {1'b1, kd});
		chk({uo, ad_out}, ad);
		chk({uoe, ad_oe_n}, 0);
		@(posedge clk);
		#1;
		chk({ale, st}, {1'b0, kd});
		chk(uo, b8 ? us : 3'h0);
		if (b8) chk(ad_out[15:8], ad[15:8]);
		if (kd == 0) chk(ad_out[15:13], ad[15:13]);
		if (kd == 2 || kd == 6) chk(ad_out & m, d & m);
		if (kd inside {1, 3, 4, 5}) chk(ad_oe_n, b8 ? 16'h00ff : 16'hffff);
		@(posedge clk);
		#1;
		chk(st, 3'h7);
		if (kd inside {0, 1, 4, 5}) begin
			x = ad[15:0] ^ 16'ha5a5;
			// The cascade code keeps the top lines driven, so they read back as the code.
			if (kd == 0) x[15:13] = ad[15:13];
			@(posedge clk);
			#1;
			chk({rv, rd}, {1'b1, x & m});
		end
	endtask
	task automatic refuse();
		@(posedge clk);
		v <= 1;
		k <= 3'h7;
		repeat (3) begin
			@(posedge clk);
			#1;
			chk({ale, st, uoe}, {1'b0, 3'h7, 3'h7});
		end
		@(posedge clk);
		v <= 0;
	endtask
	initial begin
		rs(0);
		for (int i = 0; i < 7; i++) go(i[2:0], 19'h5b3c1 + i, 16'hc3e1 ^ i[15:0]);
		refuse();
		rs(1);
		go(3'h5, 19'h2a55a, 16'h0);
		go(3'h6, 19'h7c3a5, 16'h1234);
		go(3'h0, 19'h4e0f3, 16'h0);
		conclude();
	end
endmodule
